// file: inc/dma_pkg.sv
package dma_pkg;
  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] COUNT_LAST = 16'hFFFF;
  // ************************************************************
  // Data path codes, source in [7:4], destination in [3:0]
  // ************************************************************
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 4;
  localparam int DST_HI = 3;
  localparam int DST_LO = 0;
  localparam logic [3:0] PATH_OFF = 4'h0;
  localparam logic [3:0] PATH_SER0 = 4'h1;
  localparam logic [3:0] PATH_SER1 = 4'h2;
  localparam logic [3:0] PATH_TWO_WIRE = 4'h5;
  localparam logic [3:0] PATH_SPI = 4'h7;
  localparam logic [3:0] PATH_ANALOG = 4'h9;
  localparam logic [3:0] PATH_CRC = 4'hD;
  localparam logic [3:0] PATH_RAM = 4'hF;
  // ************************************************************
  // Trigger sources
  // ************************************************************
  localparam logic [1:0] TRIG_SW = 2'h0;
  localparam logic [1:0] TRIG_EXT2 = 2'h1;
  localparam logic [1:0] TRIG_RSVD = 2'h2;
  localparam logic [1:0] TRIG_KEYPAD = 2'h3;
  // ************************************************************
  // Transaction sequencer
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_RDWAIT = 5'b00100,
    ST_RDTAKE = 5'b01000,
    ST_DRAIN = 5'b10000
  } dma_state_e;
endpackage : dma_pkg

// file: verilog/byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] cnt;
  logic ov;
  logic [WIDTH-1:0] od;
  wire push = in_valid_in && (cnt < CW'(DEPTH));
  wire pop = ov && out_ready_in;
  wire load = !ov || pop;
  wire from_mem = load && (cnt != '0);
  wire bypass = load && (cnt == '0) && push;
  wire mem_wr = push && !bypass;
  assign in_ready_out = (cnt < CW'(DEPTH));
  assign out_valid_out = ov;
  assign out_data_out = od;
  // Storage words, the output word is a register ahead of them
  always_ff @(posedge clk_in) begin
    if (mem_wr) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end else begin
      if (mem_wr) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (from_mem) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      cnt <= cnt + CW'(mem_wr) - CW'(from_mem);
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ov <= 1'b0;
      od <= '0;
    end else if (flush_in) begin
      ov <= 1'b0;
    end else if (from_mem) begin
      ov <= 1'b1;
      od <= mem[rd_ptr];
    end else if (bypass) begin
      ov <= 1'b1;
      od <= in_data_in;
    end else if (pop) begin
      ov <= 1'b0;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// file: verilog/block_dma.sv
`timescale 1ns/100ps
`default_nettype none
module block_dma (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic controller_enable_bit_in,
  input wire logic run_write_in,
  input wire logic run_wdata_in,
  input wire logic completion_clear_in,
  input wire logic completion_irq_enable_in,
  input wire logic global_dma_irq_enable_in,
  input wire logic [7:0] data_path_selector_in,
  input wire logic [1:0] trigger_source_field_in,
  input wire logic loop_mode_bit_in,
  input wire logic crc_copy_enable_in,
  input wire logic ext_irq2_event_in,
  input wire logic keypad_event_in,
  input wire logic count_current_write_in,
  input wire logic count_base_write_in,
  input wire logic [dma_pkg::CNT_W-1:0] count_wdata_in,
  input wire logic address_current_write_in,
  input wire logic address_base_write_in,
  input wire logic [dma_pkg::CNT_W-1:0] address_wdata_in,
  input wire logic counter_timer_run_in,
  input wire logic address_timer_run_in,
  input wire logic counter_timer_irq_enable_in,
  input wire logic address_timer_irq_enable_in,
  input wire logic counter_timer_flag_clear_in,
  input wire logic address_timer_flag_clear_in,
  input wire logic src_valid_in,
  input wire logic [dma_pkg::DATA_W-1:0] src_data_in,
  output logic src_ack_out,
  input wire logic dst_ready_in,
  output logic dst_valid_out,
  output logic [dma_pkg::DATA_W-1:0] dst_data_out,
  output logic crc_write_out,
  output logic [dma_pkg::DATA_W-1:0] crc_data_out,
  output logic ram_rd_out,
  output logic ram_wr_out,
  output logic [dma_pkg::CNT_W-1:0] ram_addr_out,
  output logic [dma_pkg::DATA_W-1:0] ram_wdata_out,
  input wire logic [dma_pkg::DATA_W-1:0] ram_rdata_in,
  output logic transfer_run_bit_out,
  output logic completion_flag_out,
  output logic [dma_pkg::CNT_W-1:0] count_current_out,
  output logic [dma_pkg::CNT_W-1:0] address_current_out,
  output logic counter_timer_overflow_flag_out,
  output logic address_timer_overflow_flag_out,
  output logic irq_out
);
  import dma_pkg::*;
  // ************************************************************
  // Path decode
  // ************************************************************
  // Legal code check
  function automatic logic path_ok(input logic [3:0] code, input logic is_src);
    logic common;
    common = (code == PATH_SER0) || (code == PATH_SER1) || (code == PATH_TWO_WIRE) ||
             (code == PATH_SPI) || (code == PATH_RAM);
    path_ok = common || (is_src ? (code == PATH_ANALOG) : (code == PATH_CRC));
  endfunction : path_ok

  dma_state_e state;
  dma_state_e next_state;
  logic [CNT_W-1:0] count_cur;
  logic [CNT_W-1:0] count_base;
  logic [CNT_W-1:0] addr_cur;
  logic [CNT_W-1:0] addr_base;
  logic run;
  logic flag;
  logic tf_count;
  logic tf_addr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  wire [3:0] src_code = data_path_selector_in[SRC_HI:SRC_LO];
  wire [3:0] dst_code = data_path_selector_in[DST_HI:DST_LO];
  wire src_ram = (src_code == PATH_RAM);
  wire dst_ram = (dst_code == PATH_RAM);
  wire dst_crc = (dst_code == PATH_CRC);
  wire path_good = path_ok(src_code, 1'b1) && path_ok(dst_code, 1'b0);
  wire enable = controller_enable_bit_in;
  wire ext_trig = ((trigger_source_field_in == TRIG_EXT2) && ext_irq2_event_in) ||
                  ((trigger_source_field_in == TRIG_KEYPAD) && keypad_event_in);
  wire start = enable && run && path_good;
  // Source byte present and buffer has room
  wire src_take = (state == ST_FETCH) && enable && !src_ram && src_valid_in && fifo_in_ready;
  wire rd_issue = (state == ST_FETCH) && enable && src_ram && fifo_in_ready;
  wire push = src_take || ((state == ST_RDTAKE) && enable);
  wire [DATA_W-1:0] push_data = (state == ST_RDTAKE) ? ram_rdata_in : src_data_in;
  wire xfer_done = (state == ST_DRAIN) && enable && fifo_out_valid && (dst_ram || dst_ready_in);
  wire count_wrap = (count_cur == COUNT_LAST);
  // End of transfer on count wrap
  wire end_evt = xfer_done && count_wrap;

  // ************************************************************
  // Byte buffer
  // ************************************************************
  // Flushing on disable drops a half-moved byte; counters are not yet stepped for it
  byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(!enable),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(xfer_done),
    .out_data_out(fifo_out_data)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Run is only sampled between transactions
  // Enable low aborts from any state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!enable) begin
          next_state = ST_IDLE;
        end else if (rd_issue) begin
          next_state = ST_RDWAIT;
        end else if (src_take) begin
          next_state = ST_DRAIN;
        end
      end
      ST_RDWAIT: begin
        next_state = enable ? ST_RDTAKE : ST_IDLE;
      end
      ST_RDTAKE: begin
        next_state = enable ? ST_DRAIN : ST_IDLE;
      end
      ST_DRAIN: begin
        if (!enable || xfer_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Count and address counters
  // ************************************************************
  // Timer stepping while DMA is disabled
  wire count_tick = enable ? xfer_done : counter_timer_run_in;
  wire addr_tick = enable ? xfer_done : address_timer_run_in;
  wire count_tmr_wrap = !enable && counter_timer_run_in && count_wrap;
  wire addr_tmr_wrap = !enable && address_timer_run_in && (addr_cur == COUNT_LAST);
  // Reload both from bases at end of transfer
  wire addr_reload = (enable && end_evt) || addr_tmr_wrap;
  // A write wins over a step in the same cycle
  wire [CNT_W-1:0] next_count = count_current_write_in ? count_wdata_in :
                                (count_tick && count_wrap) ? count_base :
                                count_tick ? count_cur + 1'b1 : count_cur;
  wire [CNT_W-1:0] next_addr = address_current_write_in ? address_wdata_in :
                               addr_reload ? addr_base :
                               addr_tick ? addr_cur + 1'b1 : addr_cur;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_cur <= COUNT_RESET;
      addr_cur <= ADDR_RESET;
      count_base <= COUNT_RESET;
      addr_base <= ADDR_RESET;
    end else begin
      count_cur <= next_count;
      addr_cur <= next_addr;
      count_base <= count_base_write_in ? count_wdata_in : count_base;
      addr_base <= address_base_write_in ? address_wdata_in : addr_base;
    end
  end

  // ************************************************************
  // Control and status bits
  // ************************************************************
  wire run_kept = run_write_in ? run_wdata_in : run;
  // External or software set, hardware clear at end unless in loop mode
  wire next_run = (enable && ext_trig) || (run_write_in && run_wdata_in) ||
                  (run_kept && !(end_evt && !loop_mode_bit_in));
  wire next_flag = end_evt || (flag && !completion_clear_in);
  wire next_tf_count = count_tmr_wrap || (tf_count && !counter_timer_flag_clear_in);
  wire next_tf_addr = addr_tmr_wrap || (tf_addr && !address_timer_flag_clear_in);
  wire next_irq = global_dma_irq_enable_in && ((completion_irq_enable_in && flag) ||
                  (counter_timer_irq_enable_in && tf_count) || (address_timer_irq_enable_in && tf_addr));
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run <= 1'b0;
      flag <= 1'b0;
      tf_count <= 1'b0;
      tf_addr <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      run <= next_run;
      flag <= next_flag;
      tf_count <= next_tf_count;
      tf_addr <= next_tf_addr;
      irq_out <= next_irq;
    end
  end

  // ************************************************************
  // Peripheral and RAM strobes
  // ************************************************************
  // CRC gets destination writes and copies
  wire crc_hit = xfer_done && (dst_crc || crc_copy_enable_in);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_ack_out <= 1'b0;
      ram_rd_out <= 1'b0;
      ram_wr_out <= 1'b0;
      dst_valid_out <= 1'b0;
      crc_write_out <= 1'b0;
    end else begin
      src_ack_out <= src_take;
      ram_rd_out <= rd_issue;
      ram_wr_out <= xfer_done && dst_ram;
      dst_valid_out <= xfer_done && !dst_ram && !dst_crc;
      crc_write_out <= crc_hit;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ram_addr_out <= ADDR_RESET;
      ram_wdata_out <= '0;
      dst_data_out <= '0;
      crc_data_out <= '0;
    end else begin
      if (rd_issue || xfer_done) begin
        ram_addr_out <= addr_cur;
      end
      if (xfer_done) begin
        ram_wdata_out <= fifo_out_data;
        dst_data_out <= fifo_out_data;
        crc_data_out <= fifo_out_data;
      end
    end
  end
  assign transfer_run_bit_out = run;
  assign completion_flag_out = flag;
  assign count_current_out = count_cur;
  assign address_current_out = addr_cur;
  assign counter_timer_overflow_flag_out = tf_count;
  assign address_timer_overflow_flag_out = tf_addr;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // A disable during the wait ends the read early, so the second step allows it
  sequence ram_read_s;
    ram_rd_out && state == ST_RDWAIT && ram_addr_out == $past(addr_cur) ##1 state == ST_RDTAKE || !$past(enable);
  endsequence
  ram_read_a: assert property (rd_issue |=> ram_read_s)
    else $error("RAM read sequence broken");
  end_flag_a: assert property (end_evt && !count_current_write_in
    |=> flag && count_cur == $past(count_base))
    else $error("End of transfer did not set flag or reload count");
  addr_reload_a: assert property (end_evt && !address_current_write_in |=> addr_cur == $past(addr_base))
    else $error("Address not reloaded at end");
  run_clear_a: assert property (end_evt && !loop_mode_bit_in && !run_write_in && !ext_trig |=> !run)
    else $error("Run bit not cleared at end");
  loop_keep_a: assert property (end_evt && loop_mode_bit_in && run && !run_write_in |=> run)
    else $error("Loop mode dropped run");
  count_step_a: assert property (xfer_done && !count_wrap && !count_current_write_in
    |=> count_cur == $past(count_cur) + 16'h0001)
    else $error("Count did not step by one");
  flag_hold_a: assert property (flag && !completion_clear_in |=> flag)
    else $error("Completion flag lost");
  abort_a: assert property (!enable && state != ST_IDLE |=> state == ST_IDLE)
    else $error("Disable did not stop the transfer");
  suspend_a: assert property (state == ST_IDLE && !run |=> state == ST_IDLE)
    else $error("Started while suspended");
  src_wait_a: assert property (state == ST_FETCH && enable && !src_ram && !src_valid_in
    |=> state == ST_FETCH && !src_ack_out)
    else $error("Moved without source data");
  crc_copy_a: assert property (xfer_done && crc_copy_enable_in |=> crc_write_out
    && crc_data_out == $past(fifo_out_data))
    else $error("CRC copy missing");
  irq_a: assert property (global_dma_irq_enable_in && completion_irq_enable_in && flag |=> irq_out)
    else $error("Interrupt not raised");
endmodule : block_dma
`default_nettype wire

// file: tb/periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Source and destination peripherals with a synchronous RAM
// ************************************************************
module periph_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic src_ack_in,
  output logic src_valid_out,
  output logic [7:0] src_data_out,
  output logic dst_ready_out,
  input wire logic ram_rd_in,
  input wire logic ram_wr_in,
  input wire logic [15:0] ram_addr_in,
  input wire logic [7:0] ram_wdata_in,
  output logic [7:0] ram_rdata_out
);
  logic [7:0] mem [0:1023];
  logic [7:0] next_byte = 8'h10;
  initial begin
    src_valid_out = 1'b0;
    src_data_out = 8'hA5;
    ram_rdata_out = 8'h5A;
  end
  // Stall holds both ends back, so the waits show at the ports
  assign dst_ready_out = !stall_in;
  // A released source shows the inverse of its last byte, never a stale copy
  // No parity; the acknowledge releases the byte
  always @(posedge clk_in) begin
    if (src_ack_in) begin
      src_valid_out <= 1'b0;
      src_data_out <= ~src_data_out;
      next_byte <= next_byte + 8'h01;
    end else if (!src_valid_out && !stall_in) begin
      src_valid_out <= 1'b1;
      src_data_out <= next_byte;
    end
  end
  // Read data is good for one cycle only
  always @(posedge clk_in) begin
    if (ram_wr_in) begin
      mem[ram_addr_in[9:0]] <= ram_wdata_in;
    end
    ram_rdata_out <= ram_rd_in ? mem[ram_addr_in[9:0]] : ~ram_rdata_out;
  end
endmodule : periph_model
`default_nettype wire

// file: tb/single_channel_block_dma_tb.sv
`timescale 1ns/100ps
`default_nettype none
module single_channel_block_dma_tb;
  import dma_pkg::*;
  logic clk_in, rst_in, controller_enable_bit_in, run_write_in, run_wdata_in, completion_clear_in;
  logic completion_irq_enable_in, global_dma_irq_enable_in, loop_mode_bit_in, crc_copy_enable_in;
  logic ext_irq2_event_in, keypad_event_in, count_current_write_in, count_base_write_in;
  logic address_current_write_in, address_base_write_in, counter_timer_run_in, address_timer_run_in;
  logic counter_timer_irq_enable_in, address_timer_irq_enable_in, counter_timer_flag_clear_in;
  logic address_timer_flag_clear_in, src_valid_in, src_ack_out, dst_ready_in, dst_valid_out, crc_write_out;
  logic ram_rd_out, ram_wr_out, transfer_run_bit_out, completion_flag_out, counter_timer_overflow_flag_out;
  logic address_timer_overflow_flag_out, irq_out, stall;
  logic [7:0] data_path_selector_in, src_data_in, dst_data_out, crc_data_out, ram_wdata_out, ram_rdata_in;
  logic [7:0] dst_last, crc_last;
  logic [1:0] trigger_source_field_in;
  logic [15:0] count_wdata_in, address_wdata_in, ram_addr_out, count_current_out, address_current_out;
  int fails = 0, comparisons = 0, dst_n = 0, crc_n = 0, wr_n = 0, rd_n = 0, i, n;
  block_dma dut (.*);
  periph_model model (.clk_in(clk_in), .stall_in(stall), .src_ack_in(src_ack_out), .src_valid_out(src_valid_in),
    .src_data_out(src_data_in), .dst_ready_out(dst_ready_in), .ram_rd_in(ram_rd_out), .ram_wr_in(ram_wr_out),
    .ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out), .ram_rdata_out(ram_rdata_in));
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic pause(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask : pause
  task automatic run(input logic v);
    @(posedge clk_in);
    run_write_in <= 1'b1;
    run_wdata_in <= v;
    @(posedge clk_in);
    run_write_in <= 1'b0;
  endtask : run
  task automatic setup(input logic [7:0] path, input logic [15:0] c, input logic [15:0] a);
    @(posedge clk_in);
    data_path_selector_in <= path;
    {count_current_write_in, count_base_write_in, address_current_write_in, address_base_write_in} <= 4'hF;
    count_wdata_in <= c;
    address_wdata_in <= a;
    @(posedge clk_in);
    {count_current_write_in, count_base_write_in, address_current_write_in, address_base_write_in} <= 4'h0;
  endtask : setup
  task automatic clear();
    @(posedge clk_in);
    completion_clear_in <= 1'b1;
    @(posedge clk_in);
    completion_clear_in <= 1'b0;
  endtask : clear
  // Bounded so a block that never ends cannot hang the run
  task automatic wait_end();
    @(negedge clk_in);
    for (n = 0; n < 3000 && completion_flag_out !== 1'b1; n++) begin
      @(negedge clk_in);
    end
    if (n == 3000) begin
      fails++;
      $display("wrong value at %0t: block never ended", $time);
    end
    pause(2);
  endtask : wait_end
  task automatic print_verdict();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // ************************************************************
  // Observers, clock and watchdog
  // ************************************************************
  always @(posedge clk_in) begin
    if (dst_valid_out === 1'b1) begin
      dst_n <= dst_n + 1;
      dst_last <= dst_data_out;
    end
    if (crc_write_out === 1'b1) begin
      crc_n <= crc_n + 1;
      crc_last <= crc_data_out;
    end
    if (ram_wr_out === 1'b1) begin
      chk(ram_addr_out, 16'(16'h0020 + wr_n), "ram write address");
      chk(16'(ram_wdata_out), 16'(8'h14 + wr_n), "ram write data");
      wr_n <= wr_n + 1;
    end
    if (ram_rd_out === 1'b1) begin
      chk(ram_addr_out, 16'(16'h0020 + rd_n), "ram read address");
      rd_n <= rd_n + 1;
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    repeat (6000) @(posedge clk_in);
    fails++;
    print_verdict();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    rst_in = 1'b1;
    {controller_enable_bit_in, run_write_in, run_wdata_in, completion_clear_in, completion_irq_enable_in,
      global_dma_irq_enable_in, loop_mode_bit_in, crc_copy_enable_in, ext_irq2_event_in, keypad_event_in,
      count_current_write_in, count_base_write_in, address_current_write_in, address_base_write_in,
      counter_timer_run_in, address_timer_run_in, counter_timer_irq_enable_in, address_timer_irq_enable_in,
      counter_timer_flag_clear_in, address_timer_flag_clear_in, stall} = '0;
    {data_path_selector_in, trigger_source_field_in, count_wdata_in, address_wdata_in} = '0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    pause(1);
    chk(count_current_out, COUNT_RESET, "count reset");
    chk(address_current_out, ADDR_RESET, "address reset");
    @(posedge clk_in);
    {completion_irq_enable_in, global_dma_irq_enable_in, controller_enable_bit_in} <= 3'h7;
    setup(8'h11, 16'hFFFC, 16'h0010);
    run(1'b1);
    wait_end();
    chk(16'(dst_n), 16'h0004, "block length");
    chk(dst_last, 8'h13, "last byte");
    chk(transfer_run_bit_out, 1'b0, "run end");
    chk(count_current_out, 16'hFFFC, "count reload");
    chk(address_current_out, 16'h0010, "address reload");
    chk(irq_out, 1'b1, "irq");
    pause(4);
    chk(completion_flag_out, 1'b1, "flag held");
    @(posedge clk_in);
    global_dma_irq_enable_in <= 1'b0;
    pause(2);
    chk(irq_out, 1'b0, "irq masked");
    clear();
    pause(1);
    chk(completion_flag_out, 1'b0, "flag clear");
    setup(8'h2F, 16'hFFFE, 16'h0020);
    run(1'b1);
    wait_end();
    chk(address_current_out, 16'h0020, "ram base");
    chk(16'(wr_n), 16'h0002, "ram writes");
    clear();
    @(posedge clk_in);
    crc_copy_enable_in <= 1'b1;
    setup(8'hF7, 16'hFFFE, 16'h0020);
    run(1'b1);
    wait_end();
    chk(dst_last, 8'h15, "ram to spi");
    chk(16'(crc_n), 16'h0002, "crc copies");
    chk(crc_last, 8'h15, "crc byte");
    chk(16'(rd_n), 16'h0002, "ram reads");
    clear();
    @(posedge clk_in);
    {crc_copy_enable_in, stall} <= 2'b01;
    setup(8'h11, 16'hFFF8, 16'h0000);
    run(1'b1);
    pause(10);
    chk(count_current_out, 16'hFFF8, "stalled");
    run(1'b0);
    @(posedge clk_in);
    stall <= 1'b0;
    pause(20);
    chk(count_current_out, 16'hFFF9, "suspend");
    run(1'b1);
    wait_end();
    chk(dst_last, 8'h1D, "resume");
    clear();
    for (i = 0; i < 3; i++) begin
      @(posedge clk_in);
      trigger_source_field_in <= (i == 0) ? TRIG_EXT2 : (i == 1) ? TRIG_KEYPAD : TRIG_RSVD;
      setup(8'h11, 16'hFFFF, 16'h0000);
      {ext_irq2_event_in, keypad_event_in} <= (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b11;
      @(posedge clk_in);
      {ext_irq2_event_in, keypad_event_in} <= 2'b00;
      pause(30);
      chk(completion_flag_out, 16'(i < 2), "event start");
      chk(transfer_run_bit_out, 1'b0, "event end");
      clear();
    end
    @(posedge clk_in);
    {trigger_source_field_in, loop_mode_bit_in} <= 3'b001;
    setup(8'h11, 16'hFFFE, 16'h0000);
    run(1'b1);
    wait_end();
    chk(transfer_run_bit_out, 1'b1, "loop run");
    clear();
    wait_end();
    chk(completion_flag_out, 1'b1, "loop again");
    @(posedge clk_in);
    controller_enable_bit_in <= 1'b0;
    pause(2);
    n = dst_n;
    pause(20);
    chk(16'(dst_n - n), 16'h0000, "stopped");
    run(1'b0);
    clear();
    @(posedge clk_in);
    {controller_enable_bit_in, loop_mode_bit_in} <= 2'b10;
    setup(8'h33, 16'hFFFF, 16'h0000);
    run(1'b1);
    pause(20);
    chk(count_current_out, 16'hFFFF, "bad path");
    run(1'b0);
    @(posedge clk_in);
    controller_enable_bit_in <= 1'b0;
    {completion_irq_enable_in, global_dma_irq_enable_in, counter_timer_irq_enable_in} <= 3'b011;
    setup(8'h00, 16'hFFFD, 16'hFFFE);
    {counter_timer_run_in, address_timer_run_in} <= 2'h3;
    pause(6);
    chk(counter_timer_overflow_flag_out, 1'b1, "count timer");
    chk(address_timer_overflow_flag_out, 1'b1, "address timer");
    chk(irq_out, 1'b1, "timer irq");
    @(posedge clk_in);
    {counter_timer_run_in, address_timer_run_in, counter_timer_flag_clear_in, address_timer_flag_clear_in} <= 4'h3;
    @(posedge clk_in);
    {counter_timer_flag_clear_in, address_timer_flag_clear_in} <= 2'h0;
    pause(2);
    chk(counter_timer_overflow_flag_out, 1'b0, "count timer clear");
    chk(address_timer_overflow_flag_out, 1'b0, "address timer clear");
    chk(irq_out, 1'b0, "timer irq clear");
    print_verdict();
  end
endmodule : single_channel_block_dma_tb
`default_nettype wire
